// >>> rsmu_mask_gen.sv
// rotate left by width minus n and low-ones mask generator of the right-shift merge unit
module rsmu_mask_gen
#(
    parameter int W  = 32,
    parameter int SW = 5
)(
    input  wire logic [W-1:0]  src_word,
    input  wire logic [SW-1:0] shift_amt,
    output logic      [W-1:0]  rot_word,
    output logic      [W-1:0]  low_mask
);
    logic [2*W-1:0] dbl_word;

    // rotating left by W-n is rotating right by n
    assign dbl_word = {src_word, src_word} >> shift_amt;
    assign rot_word = dbl_word[W-1:0];
    // n zeros from the most significant end, then ones
    assign low_mask = {W{1'b1}} >> shift_amt;
endmodule

// >>> rsmu_core.sv
// right-shift merge unit: shift with merge, shift with aux load, plain shift word
// Notes on behaviour
// RULE1: shift amount is control low five bits; source rotated left by 32 minus it.
// RULE2: long merge, zero-select clear: low-ones mask merges rotated word with aux register.
// RULE3: long merge, zero-select set: high-ones mask merges zero word with aux register.
// RULE4: long merge writes target only; aux register stays unchanged.
// RULE5: aux-load shift writes full rotated word into aux register always.
// RULE6: aux-load and plain shift use low-ones mask when zero-select is clear.
// RULE7: aux-load and plain shift use all-zero mask when zero-select is set.
// RULE8: aux-load shift writes rotated word AND mask into target.
// RULE9: plain shift word writes rotated AND mask; both mnemonics identical.
// RULE10: record flag set updates condition field zero; clear leaves it untouched.
// RULE11: no operation touches the fixed-point exception register; no overflow form.
// RULE12: aux-load and long merge only in legacy mode; plain shift always accepted.
// RULE13: mask one selects rotated or zero word bit; mask zero selects aux bit.
// RULE14: big-endian numbering; bits 27-31 are low five, bit 26 weighs 32.
// RULE15: primary 31 with extended 664 aux-load, 536 plain shift; bit 31 record.
//
// Chosen here: the register offsets and the strobed register port.

// shared constants of the right-shift merge unit
package rsmu_pkg;
    localparam int          DATA_W        = 32;
    localparam int          SHAMT_W       = 5;
    localparam int          REG_ADDR_W    = 4;
    // instruction field positions, little-endian view of the big-endian word
    localparam int          PRIMARY_HI    = 31;
    localparam int          PRIMARY_LO    = 26;
    localparam int          SRC_IDX_HI    = 25;
    localparam int          SRC_IDX_LO    = 21;
    localparam int          TGT_IDX_HI    = 20;
    localparam int          TGT_IDX_LO    = 16;
    localparam int          CTL_IDX_HI    = 15;
    localparam int          CTL_IDX_LO    = 11;
    localparam int          XO_HI         = 10;
    localparam int          XO_LO         = 1;
    localparam int          RECORD_BIT    = 0;
    // shift-control operand: big-endian bits 27-31 and 26
    localparam int          SHAMT_HI      = 4;
    localparam int          SHAMT_LO      = 0;
    localparam int          ZERO_SEL_BIT  = 5;
    // opcodes
    localparam logic [5:0]  OPC_PRIMARY   = 6'h1F;
    localparam logic [9:0]  XO_SHIFT_AUX  = 10'h298;
    localparam logic [9:0]  XO_SHIFT_WORD = 10'h218;
    localparam logic [9:0]  XO_LONG_MERGE = 10'h2D8;
    // software register map, byte addresses
    localparam logic [3:0]  OFS_AUX       = 4'h0;
    localparam logic [3:0]  OFS_STATUS    = 4'h4;
    localparam logic [3:0]  OFS_CTRL      = 4'h8;
    // status and control fields
    localparam int          ST_CR0_HI     = 3;
    localparam int          ST_CR0_LO     = 0;
    localparam int          ST_ILLEGAL    = 4;
    localparam int          CTRL_LEGACY   = 0;
    localparam logic [31:0] AUX_RESET     = 32'h0000_0000;
    localparam logic        LEGACY_RESET  = 1'b1;
    localparam int          IDX_W         = 5;
    localparam int          CR_W          = 4;
endpackage

module rsmu_core
    import rsmu_pkg::*;
#(
    parameter int W = DATA_W
)(
    input  wire logic                  sys_clk,
    input  wire logic                  resetn,
    input  wire logic                  issue_valid,
    input  wire logic [31:0]           instr_word,
    input  wire logic [W-1:0]          source_reg,
    input  wire logic [W-1:0]          shift_ctrl_reg,
    input  wire logic                  summary_ovf_in,
    output logic                       wb_valid,
    output logic      [IDX_W-1:0]      wb_target_idx,
    output logic      [W-1:0]          target_reg,
    output logic                       cr0_we,
    output logic      [CR_W-1:0]       cr0_value,
    output logic                       illegal_op,
    output logic      [W-1:0]          multiply_quotient_reg,
    input  wire logic [REG_ADDR_W-1:0] reg_addr,
    input  wire logic [31:0]           reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output logic      [31:0]           reg_rdata
);

    // true when the word carries the given extended opcode under primary 31
    function automatic logic op_match(input logic [31:0] iw, input logic [9:0] xo);
        logic hit;
        hit = (iw[PRIMARY_HI:PRIMARY_LO] == OPC_PRIMARY) && (iw[XO_HI:XO_LO] == xo);
        return hit;
    endfunction

    // registers
    logic [W-1:0]       aux_ff;
    logic [W-1:0]       nxt_aux;
    logic               legacy_en_ff;
    logic               nxt_legacy_en;
    logic               illegal_seen_ff;
    logic               nxt_illegal_seen;
    logic [CR_W-1:0]    last_cr0_ff;
    logic [CR_W-1:0]    nxt_last_cr0;
    logic               wb_valid_ff;
    logic [IDX_W-1:0]   wb_idx_ff;
    logic [W-1:0]       wb_data_ff;
    logic               cr0_we_ff;
    logic [CR_W-1:0]    cr0_val_ff;
    logic               illegal_ff;
    logic [31:0]        rdata_ff;
    logic [31:0]        nxt_rdata;

    // decode
    logic               is_shift_aux;
    logic               is_shift_word;
    logic               is_long_merge;
    logic               is_legacy_op;
    logic               is_any_op;
    logic               op_refused;
    logic               op_accept;
    logic               record_flag;
    logic [SHAMT_W-1:0] shamt;
    logic               zero_sel;

    // datapath
    logic [W-1:0]       rot_word;
    logic [W-1:0]       low_mask;
    logic [W-1:0]       and_mask;
    logic [W-1:0]       merge_mask;
    logic [W-1:0]       merge_src;
    logic [W-1:0]       merged_word;
    logic [W-1:0]       masked_word;
    logic [W-1:0]       result_word;
    logic               neg_flag;
    logic               pos_flag;
    logic               zero_flag;
    logic [CR_W-1:0]    cr0_next;

    // software access
    logic               wr_aux;
    logic               wr_status;
    logic               wr_ctrl;
    logic               aux_load_hw;
    logic [31:0]        status_word;
    logic [31:0]        ctrl_word;

    // opcode decode; the two plain-shift mnemonics share one encoding
    assign is_shift_aux  = issue_valid && op_match(instr_word, XO_SHIFT_AUX);  // RULE15
    assign is_shift_word = issue_valid && op_match(instr_word, XO_SHIFT_WORD); // RULE15 RULE9
    assign is_long_merge = issue_valid && op_match(instr_word, XO_LONG_MERGE);
    assign record_flag   = instr_word[RECORD_BIT];                             // RULE15
    assign is_legacy_op  = is_shift_aux || is_long_merge;
    assign is_any_op     = is_legacy_op || is_shift_word;

    // legacy-only forms are refused while legacy mode is off
    assign op_refused    = is_legacy_op && !legacy_en_ff;                      // RULE12
    assign op_accept     = is_any_op && !op_refused;                           // RULE12

    // shift-control fields in big-endian numbering
    assign shamt         = shift_ctrl_reg[SHAMT_HI:SHAMT_LO];                  // RULE1 RULE14
    assign zero_sel      = shift_ctrl_reg[ZERO_SEL_BIT];                       // RULE14

    // rotate and base mask
    rsmu_mask_gen #(
        .W  (W),
        .SW (SHAMT_W)
    ) rsmu_mask_gen_inst (
        .src_word  (source_reg),
        .shift_amt (shamt),
        .rot_word  (rot_word),                                                 // RULE1
        .low_mask  (low_mask)
    );

    // long merge: pick mask and data by the zero-select bit
    assign merge_mask    = zero_sel ? ~low_mask : low_mask;                    // RULE2 RULE3
    assign merge_src     = zero_sel ? '0 : rot_word;                           // RULE2 RULE3
    // mask one takes the rotated or zero bit, mask zero takes the aux bit
    assign merged_word   = (merge_src & merge_mask) | (aux_ff & ~merge_mask);  // RULE13

    // and-mask forms: all-zero mask forces a zero result
    assign and_mask      = zero_sel ? '0 : low_mask;                           // RULE6 RULE7
    assign masked_word   = rot_word & and_mask;                                // RULE8 RULE9

    // result select
    assign result_word   = is_long_merge ? merged_word : masked_word;          // RULE4

    // condition field zero: negative, positive, zero, summary overflow copied in
    assign neg_flag      = result_word[W-1];
    assign zero_flag     = (result_word == '0);
    assign pos_flag      = !neg_flag && !zero_flag;
    // summary overflow is only read, never written back
    assign cr0_next      = {neg_flag, pos_flag, zero_flag, summary_ovf_in};    // RULE10 RULE11

    // register write decode
    assign wr_aux        = reg_wr && (reg_addr == OFS_AUX);
    assign wr_status     = reg_wr && (reg_addr == OFS_STATUS);
    assign wr_ctrl       = reg_wr && (reg_addr == OFS_CTRL);

    // only the aux-load shift loads the aux register; long merge leaves it
    assign aux_load_hw   = op_accept && is_shift_aux;                          // RULE4 RULE5

    // aux register next value: instruction load wins over a software write
    assign nxt_aux       = aux_load_hw ? rot_word :                            // RULE5
                           wr_aux      ? reg_wdata[W-1:0] :
                                         aux_ff;

    // legacy enable bit from the control register
    assign nxt_legacy_en = wr_ctrl ? reg_wdata[CTRL_LEGACY] : legacy_en_ff;

    // sticky refused-op flag: write one clears, a new refusal wins
    assign nxt_illegal_seen = op_refused ? 1'b1 :
                              (wr_status && reg_wdata[ST_ILLEGAL]) ? 1'b0 :
                                                                     illegal_seen_ff;

    // last recorded condition value for software
    assign nxt_last_cr0  = (op_accept && record_flag) ? cr0_next : last_cr0_ff;

    // read views
    assign status_word   = {{(31-ST_ILLEGAL){1'b0}}, illegal_seen_ff, last_cr0_ff};
    assign ctrl_word     = {{(31-CTRL_LEGACY){1'b0}}, legacy_en_ff};

    // read mux; unmapped addresses read zero
    always_comb
    begin
        nxt_rdata = '0;
        if (!reg_rd)
        begin
            nxt_rdata = '0;
        end
        else if (reg_addr == OFS_AUX)
        begin
            nxt_rdata = {{(32-W){1'b0}}, aux_ff};
        end
        else if (reg_addr == OFS_STATUS)
        begin
            nxt_rdata = status_word;
        end
        else if (reg_addr == OFS_CTRL)
        begin
            nxt_rdata = ctrl_word;
        end
    end

    // architectural state
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            aux_ff          <= AUX_RESET[W-1:0];
            legacy_en_ff    <= LEGACY_RESET;
            illegal_seen_ff <= 1'b0;
            last_cr0_ff     <= '0;
        end
        else
        begin
            aux_ff          <= nxt_aux;
            legacy_en_ff    <= nxt_legacy_en;                                  // RULE12
            illegal_seen_ff <= nxt_illegal_seen;
            last_cr0_ff     <= nxt_last_cr0;
        end
    end

    // write-back stage, one cycle after issue
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            wb_valid_ff <= 1'b0;
            wb_idx_ff   <= '0;
            wb_data_ff  <= '0;
            cr0_we_ff   <= 1'b0;
            cr0_val_ff  <= '0;
            illegal_ff  <= 1'b0;
        end
        else
        begin
            wb_valid_ff <= op_accept;
            wb_idx_ff   <= instr_word[TGT_IDX_HI:TGT_IDX_LO];
            wb_data_ff  <= result_word;                                        // RULE8 RULE9
            cr0_we_ff   <= op_accept && record_flag;                           // RULE10
            cr0_val_ff  <= cr0_next;
            illegal_ff  <= op_refused;
        end
    end

    // register read data, valid the cycle after the strobe
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rdata_ff <= '0;
        end
        else
        begin
            rdata_ff <= nxt_rdata;
        end
    end

    // outputs
    assign wb_valid              = wb_valid_ff;
    assign wb_target_idx         = wb_idx_ff;
    assign target_reg            = wb_data_ff;
    assign cr0_we                = cr0_we_ff;
    assign cr0_value             = cr0_val_ff;
    assign illegal_op            = illegal_ff;
    assign multiply_quotient_reg = aux_ff;
    assign reg_rdata             = rdata_ff;

endmodule

// >>> rsmu_core_checker.sv
// port assertions of the right-shift merge unit core
module rsmu_core_checker
    import rsmu_pkg::*;
#(
    parameter int W = DATA_W
)(
    input wire logic             sys_clk,
    input wire logic             resetn,
    input wire logic             issue_valid,
    input wire logic [31:0]      instr_word,
    input wire logic [W-1:0]     source_reg,
    input wire logic [W-1:0]     shift_ctrl_reg,
    input wire logic             summary_ovf_in,
    input wire logic             wb_valid,
    input wire logic [IDX_W-1:0] wb_target_idx,
    input wire logic [W-1:0]     target_reg,
    input wire logic             cr0_we,
    input wire logic [CR_W-1:0]  cr0_value,
    input wire logic             illegal_op,
    input wire logic [W-1:0]     multiply_quotient_reg,
    input wire logic             reg_wr
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2*W-1:0] dbl;
    logic [W-1:0]   rot, lmask, exp_sw, exp_lm;
    logic [9:0]     xo;
    logic [4:0]     tgt;
    logic           zs, prim, op_sq, op_sw, op_lm, op_leg, op_any;
    // decode and expected results of the offered instruction
    assign xo     = instr_word[XO_HI:XO_LO];
    assign tgt    = instr_word[TGT_IDX_HI:TGT_IDX_LO];
    assign zs     = shift_ctrl_reg[ZERO_SEL_BIT];
    assign prim   = issue_valid && instr_word[PRIMARY_HI:PRIMARY_LO] == OPC_PRIMARY;
    assign op_sq  = prim && xo == XO_SHIFT_AUX;
    assign op_sw  = prim && xo == XO_SHIFT_WORD;
    assign op_lm  = prim && xo == XO_LONG_MERGE;
    assign op_leg = op_sq || op_lm;
    assign op_any = op_leg || op_sw;
    assign dbl    = {source_reg, source_reg} >> shift_ctrl_reg[SHAMT_HI:SHAMT_LO];
    assign rot    = dbl[W-1:0];
    assign lmask  = {W{1'b1}} >> shift_ctrl_reg[SHAMT_HI:SHAMT_LO];
    assign exp_sw = zs ? {W{1'b0}} : rot & lmask;
    assign exp_lm = zs ? multiply_quotient_reg & lmask : (rot & lmask) | (multiply_quotient_reg & ~lmask);

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);

    // results and side effects one cycle after the instruction
    shift_word_a: assert property (op_sw |=> wb_valid && target_reg == $past(exp_sw))
        else $error("plain shift result wrong");
    aux_load_a: assert property (op_sq ##1 wb_valid
        |-> multiply_quotient_reg == $past(rot) && target_reg == $past(exp_sw)) else $error("aux load shift wrong");
    long_merge_a: assert property (op_lm ##1 wb_valid |-> target_reg == $past(exp_lm))
        else $error("long merge result wrong");
    aux_hold_a: assert property (op_lm && !reg_wr ##1 wb_valid |-> $stable(multiply_quotient_reg))
        else $error("long merge changed aux register");
    rec_flags_a: assert property (cr0_we |-> cr0_value == {target_reg[W-1],
        !target_reg[W-1] && target_reg != {W{1'b0}}, target_reg == {W{1'b0}}, $past(summary_ovf_in)})
        else $error("condition field value wrong");
    no_record_a: assert property (op_any && !instr_word[RECORD_BIT] |=> !cr0_we)
        else $error("condition field written without record");
    refused_op_a: assert property (illegal_op |-> !wb_valid && !cr0_we && $past(op_leg))
        else $error("refusal wrong");
    wb_cause_a: assert property (wb_valid |-> $past(op_any) && wb_target_idx == $past(tgt))
        else $error("writeback without cause");

    // main scenarios reached
    cover property (op_lm && zs);
    cover property (op_sq ##2 op_lm);
    cover property (illegal_op);
endmodule

// >>> tb_right_shift_merge_unit.sv
// self-checking testbench of the right-shift merge unit core
module tb_right_shift_merge_unit
    import rsmu_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    logic                  sys_clk = 1'b0;
    logic                  resetn = 1'b0;
    logic                  issue_valid = 1'b0;
    logic [31:0]           instr_word = 32'h0;
    logic [31:0]           source_reg = 32'h0;
    logic [31:0]           shift_ctrl_reg = 32'h0;
    logic                  summary_ovf_in = 1'b1;
    logic [REG_ADDR_W-1:0] reg_addr = 4'h0;
    logic [31:0]           reg_wdata = 32'h0;
    logic                  reg_wr = 1'b0;
    logic                  reg_rd = 1'b0;
    logic                  wb_valid, cr0_we, illegal_op;
    logic [IDX_W-1:0]      wb_target_idx;
    logic [CR_W-1:0]       cr0_value;
    logic [31:0]           target_reg, multiply_quotient_reg, reg_rdata;
    int                    n_fail = 0;
    int                    cmp_count = 0;

    // clock of 10 ns
    always #5 sys_clk = ~sys_clk;

    rsmu_core rsmu_core_inst (.sys_clk(sys_clk), .resetn(resetn), .issue_valid(issue_valid),
        .instr_word(instr_word), .source_reg(source_reg), .shift_ctrl_reg(shift_ctrl_reg),
        .summary_ovf_in(summary_ovf_in), .wb_valid(wb_valid), .wb_target_idx(wb_target_idx),
        .target_reg(target_reg), .cr0_we(cr0_we), .cr0_value(cr0_value), .illegal_op(illegal_op),
        .multiply_quotient_reg(multiply_quotient_reg), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

    task automatic close_out();
        if (n_fail == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // one instruction; flags are {wb_valid, cr0_we, illegal_op}
    task automatic op(input logic [9:0] xo, input logic [4:0] tg, input logic rec, input logic [31:0] src,
                      input logic [31:0] ctl, input logic [2:0] ef, input logic [31:0] et);
        @(posedge sys_clk);
        issue_valid    <= 1'b1;
        instr_word     <= {OPC_PRIMARY, 5'h03, tg, 5'h08, xo, rec};
        source_reg     <= src;
        shift_ctrl_reg <= ctl;
        @(posedge sys_clk);
        issue_valid    <= 1'b0;
        #1;
        chk({29'h0, wb_valid, cr0_we, illegal_op}, {29'h0, ef});
        if (ef[2])
            chk(target_reg, et);
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        @(posedge sys_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask

    task automatic sc_reset();
        rd(OFS_AUX, AUX_RESET);
        rd(OFS_CTRL, {31'h0, LEGACY_RESET});
        rd(OFS_STATUS, 32'h0);
    endtask

    task automatic sc_shift_aux();
        op(XO_SHIFT_AUX, 5'h06, 1'b1, 32'hB000300F, 32'h4, 3'h6, 32'h0B000300);
        chk(multiply_quotient_reg, 32'hFB000300);
        chk({27'h0, wb_target_idx}, 32'h6);
        chk({28'h0, cr0_value}, 32'h5);
        op(XO_SHIFT_AUX, 5'h07, 1'b0, 32'h9000300F, 32'h24, 3'h4, 32'h0);
        rd(OFS_AUX, 32'hF9000300);
    endtask

    task automatic sc_long_merge();
        wr(OFS_AUX, 32'hFFFFFFFF);
        op(XO_LONG_MERGE, 5'h06, 1'b1, 32'hB0043000, 32'h4, 3'h6, 32'hFB004300);
        chk({28'h0, cr0_value}, 32'h9);
        op(XO_LONG_MERGE, 5'h06, 1'b0, 32'h9000300F, 32'h24, 3'h4, 32'h0FFFFFFF);
        rd(OFS_AUX, 32'hFFFFFFFF);
        wr(OFS_AUX, 32'h12345678);
        op(XO_LONG_MERGE, 5'h02, 1'b0, 32'hA5A5A5A5, 32'h0, 3'h4, 32'hA5A5A5A5);
        op(XO_LONG_MERGE, 5'h02, 1'b0, 32'hA5A5A5A5, 32'h20, 3'h4, 32'h12345678);
        op(XO_SHIFT_AUX, 5'h02, 1'b0, 32'hF, 32'h4, 3'h4, 32'h0);
        op(XO_LONG_MERGE, 5'h03, 1'b0, 32'h12345678, 32'h10, 3'h4, 32'hF0001234);
        chk(multiply_quotient_reg, 32'hF0000000);
    endtask

    task automatic sc_shift_word();
        @(posedge sys_clk);
        summary_ovf_in <= 1'b0;
        op(XO_SHIFT_WORD, 5'h06, 1'b1, 32'h90003000, 32'h24, 3'h6, 32'h0);
        chk({28'h0, cr0_value}, 32'h2);
        op(XO_SHIFT_WORD, 5'h06, 1'b1, 32'hB0043001, 32'hFFFFFFC4, 3'h6, 32'h0B004300);
        chk({28'h0, cr0_value}, 32'h4);
        op(XO_SHIFT_WORD, 5'h1F, 1'b1, 32'h80000000, 32'h1F, 3'h6, 32'h1);
        chk(multiply_quotient_reg, 32'hF0000000);
    endtask

    task automatic sc_refuse();
        wr(OFS_CTRL, 32'h0);
        op(XO_SHIFT_AUX, 5'h04, 1'b1, 32'hFFFFFFFF, 32'h4, 3'h1, 32'h0);
        chk(multiply_quotient_reg, 32'hF0000000);
        op(XO_LONG_MERGE, 5'h04, 1'b1, 32'hFFFFFFFF, 32'h4, 3'h1, 32'h0);
        op(XO_SHIFT_WORD, 5'h04, 1'b0, 32'h100, 32'h8, 3'h4, 32'h1);
        rd(OFS_STATUS, 32'h14);
        wr(OFS_STATUS, 32'h10);
        rd(OFS_STATUS, 32'h4);
        wr(OFS_CTRL, 32'h1);
        rd(OFS_CTRL, 32'h1);
        rd(4'hC, 32'h0);
    endtask

    // main sequence
    initial
    begin
        repeat (4) @(posedge sys_clk);
        resetn <= 1'b1;
        sc_reset();
        sc_shift_aux();
        sc_long_merge();
        sc_shift_word();
        sc_refuse();
        close_out();
    end

    // run limit against a hung sequence
    initial
    begin
        #200000;
        n_fail++;
        close_out();
    end
endmodule

bind rsmu_core rsmu_core_checker #(.W(W)) rsmu_core_checker_inst (.sys_clk(sys_clk), .resetn(resetn),
    .issue_valid(issue_valid), .instr_word(instr_word), .source_reg(source_reg), .shift_ctrl_reg(shift_ctrl_reg),
    .summary_ovf_in(summary_ovf_in), .wb_valid(wb_valid), .wb_target_idx(wb_target_idx), .target_reg(target_reg),
    .cr0_we(cr0_we), .cr0_value(cr0_value), .illegal_op(illegal_op),
    .multiply_quotient_reg(multiply_quotient_reg), .reg_wr(reg_wr));
